// ---- tp_cfg_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tp_cfg_map.svh"

module test_point_global_config_regs_bench;
    import tp_cfg_pkg::*;

    localparam logic [6:0] dev_addr = {`MGMT_ADDR_BASE, 4'h5};

    logic          clk_i;
    logic          reset_n_i;
    logic          scl;
    logic          sda_drv;
    logic [7:0]    idle_pins;
    logic [7:0]    rate_pins;
    logic [3:0]    strap_pins;
    logic          sda_o;
    logic          sda_oe_o;
    strap_pin_type strap_pin;
    tp_type        tp;
    logic [1:0]    trim;
    wire logic     sda_line;
    int            seed;
    int            bad_count;
    int            n_checks;
    logic [7:0]    r47, r4c, r4e, d;
    logic          a;

    // open-drain data wire seen by both sides
    assign sda_line = sda_drv & (sda_oe_o ? sda_o : 1'b1);

    tp_cfg_regs tp_cfg_regs_i (
        .clk_i               (clk_i),
        .reset_n_i           (reset_n_i),
        .scl_i               (scl),
        .sda_i               (sda_line),
        .sda_o               (sda_o),
        .sda_oe_o            (sda_oe_o),
        .idle_detect_i       (idle_pins),
        .rate_detect_i       (rate_pins),
        .strap_i             (strap_pins),
        .strap_pin_o         (strap_pin),
        .test_point_o        (tp),
        .global_swing_trim_o (trim)
    );

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic miss(input logic [7:0] got, input logic [7:0] exp);
        bad_count++;
        $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    endtask

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) miss(got, exp);
    endtask

    task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) miss(got, exp);
    endtask

    task automatic chk_ack(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) miss({7'h00, got}, {7'h00, exp});
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    // one bus bit: data set while clock low, wire sampled mid-high
    task automatic clk_bit(input logic b, output logic got);
        sda_drv = b;
        tick(5);
        scl = 1'b1;
        tick(3);
        got = sda_line;
        tick(2);
        scl = 1'b0;
        tick(1);
    endtask

    task automatic start_cond;
        sda_drv = 1'b1;
        tick(5);
        scl = 1'b1;
        tick(5);
        sda_drv = 1'b0;
        tick(5);
        scl = 1'b0;
        tick(1);
    endtask

    task automatic stop_cond;
        sda_drv = 1'b0;
        tick(5);
        scl = 1'b1;
        tick(5);
        sda_drv = 1'b1;
        tick(5);
    endtask

    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic x;
        for (int i = 7; i >= 0; i--) clk_bit(b[i], x);
        clk_bit(1'b1, x);
        ack = ~x;
    endtask

    task automatic rd_byte(input logic last, output logic [7:0] b);
        logic x;
        for (int i = 7; i >= 0; i--) clk_bit(1'b1, b[i]);
        clk_bit(last, x);
    endtask

    task automatic wr_reg(input logic [7:0] ad, input logic [7:0] off,
                          input logic [7:0] dat, output logic ack);
        logic a1, a2, a3;
        start_cond;
        wr_byte(ad, a1);
        wr_byte(off, a2);
        wr_byte(dat, a3);
        stop_cond;
        ack = a1 & a2 & a3;
    endtask

    task automatic rd_reg(input logic [7:0] off, output logic [7:0] dat);
        logic x;
        start_cond;
        wr_byte({dev_addr, 1'b0}, x);
        wr_byte(off, x);
        start_cond;
        wr_byte({dev_addr, 1'b1}, x);
        rd_byte(1'b1, dat);
        stop_cond;
    endtask

    // channel enable mask from the two group bits of a register
    function automatic logic [7:0] grp_en(input logic hi, input logic lo);
        return (hi ? `GROUP_HI_MASK : 8'h00) | (lo ? `GROUP_LO_MASK : 8'h00);
    endfunction

    // expected test points, strap pins and trim from register values
    task automatic chk_outputs(input logic [7:0] i47, input logic [7:0] i4c,
                               input logic [7:0] i4e);
        logic [7:0] ei, er;
        logic [3:0] es;
        ei = idle_pins & grp_en(i47[`IDLE_HI_BIT], i47[`IDLE_LO_BIT]);
        er = rate_pins & grp_en(i4c[`RATE_HI_BIT], i4c[`RATE_LO_BIT]);
        for (int i = 0; i < 4; i++) es[i] = |{ei[2*i+1 -: 2], er[2*i+1 -: 2]};
        chk_pin(tp.idle, ei);
        chk_pin(tp.rate, er);
        chk_pin({6'h00, trim}, {6'h00, i47[1:0]});
        chk_pin({4'h0, strap_pin.oe}, {4'h0, {4{i4e[`STRAP_OUT_BIT]}}});
        chk_pin({4'h0, strap_pin.out}, {4'h0, es});
    endtask

    // hang guard
    initial begin
        repeat (90000) @(posedge clk_i);
        bad_count++;
        end_sim;
    end

    // main sequence
    initial begin
        seed = 39;
        bad_count = 0;
        n_checks = 0;
        reset_n_i = 1'b0;
        scl = 1'b1;
        sda_drv = 1'b1;
        idle_pins = 8'h00;
        rate_pins = 8'h00;
        strap_pins = 4'h5;
        tick(4);
        reset_n_i = 1'b1;
        tick(10);
        rd_reg(`IDLE_TP_OFFSET, d);
        chk_reg(d, `IDLE_TP_RESET);
        rd_reg(`RATE_TP_OFFSET, d);
        chk_reg(d, `RATE_TP_RESET);
        rd_reg(`STRAP_CTRL_OFFSET, d);
        chk_reg(d, `STRAP_CTRL_RESET);
        chk_outputs(8'h02, 8'h00, 8'h00);
        rd_reg(8'h48, d);
        chk_reg(d, 8'h00);
        // straps move after latching; the old address must stay
        strap_pins = 4'hA;
        wr_reg({`MGMT_ADDR_BASE, 4'hA, 1'b0}, `IDLE_TP_OFFSET, 8'h31, a);
        chk_ack(a, 1'b0);
        rd_reg(`IDLE_TP_OFFSET, d);
        chk_reg(d, 8'h02);
        for (int k = 0; k < 10; k++) begin
            // software keeps reserved bits at zero
            r47 = 8'($random(seed)) & `IDLE_TP_MASK;
            r47[1:0] = k[1:0];
            r4c = 8'($random(seed)) & `RATE_TP_MASK;
            r4e = 8'($random(seed)) & `STRAP_CTRL_MASK;
            if (k == 0) {r47, r4c, r4e} = {`IDLE_TP_MASK, `RATE_TP_MASK, `STRAP_CTRL_MASK};
            if (k == 1) {r47, r4c, r4e} = 24'h310000;
            idle_pins = 8'($random(seed));
            rate_pins = 8'($random(seed));
            wr_reg({dev_addr, 1'b0}, `IDLE_TP_OFFSET, r47, a);
            chk_ack(a, 1'b1);
            wr_reg({dev_addr, 1'b0}, `RATE_TP_OFFSET, r4c, a);
            chk_ack(a, 1'b1);
            wr_reg({dev_addr, 1'b0}, `STRAP_CTRL_OFFSET, r4e, a);
            chk_ack(a, 1'b1);
            rd_reg(`IDLE_TP_OFFSET, d);
            chk_reg(d, r47);
            rd_reg(`RATE_TP_OFFSET, d);
            chk_reg(d, r4c);
            rd_reg(`STRAP_CTRL_OFFSET, d);
            chk_reg(d, r4e);
            tick(5);
            chk_outputs(r47, r4c, r4e);
        end
        // second reset in mid-run
        strap_pins = 4'h5;
        reset_n_i = 1'b0;
        tick(2);
        chk_pin({6'h00, trim}, 8'h02);
        reset_n_i = 1'b1;
        tick(10);
        rd_reg(`RATE_TP_OFFSET, d);
        chk_reg(d, `RATE_TP_RESET);
        end_sim;
    end
endmodule
`default_nettype wire

// ---- tp_cfg_map.svh ----
// Function
// RQ1: idle bit 5 routes idle state of channels 2,3,6,7 to test points.
// RQ2: idle bit 4 routes idle state of channels 0,1,4,5 to test points.
// RQ3: bits 1:0 trim swing of all channels; 10 is unity default.
// RQ4: rate bit 7 routes rate result of channels 2,3,6,7 to test points.
// RQ5: rate bit 6 routes rate result of channels 0,1,4,5 to test points.
// RQ6: strap bit 0 turns the four address strap pins into outputs.
// RQ7: software keeps reserved bits zero; they are plain storage only.
`ifndef TP_CFG_MAP_SVH
`define TP_CFG_MAP_SVH

// register offsets
`define IDLE_TP_OFFSET      8'h47
`define RATE_TP_OFFSET      8'h4C
`define STRAP_CTRL_OFFSET   8'h4E

// reset values
`define IDLE_TP_RESET       8'h02
`define RATE_TP_RESET       8'h00
`define STRAP_CTRL_RESET    8'h00

// field positions
`define IDLE_HI_BIT         5
`define IDLE_LO_BIT         4
`define RATE_HI_BIT         7
`define RATE_LO_BIT         6
`define STRAP_OUT_BIT       0
`define TRIM_MSB            1
`define TRIM_LSB            0

// channel groups
`define GROUP_HI_MASK       8'hCC
`define GROUP_LO_MASK       8'h33

// defined fields of each register; every other bit is reserved
`define IDLE_TP_MASK        8'h33
`define RATE_TP_MASK        8'hC0
`define STRAP_CTRL_MASK     8'h01

// management address high bits (arbitrary value)
`define MGMT_ADDR_BASE      3'h5

// cycles after reset release before straps are caught
`define STRAP_SETTLE        2'h3

`endif

// ---- tp_cfg_pkg.sv ----
package tp_cfg_pkg;

    typedef enum logic [2:0] {
        st_idle,
        st_rx,
        st_ack,
        st_tx,
        st_tx_ack,
        st_tx_next
    } state_type;

    typedef enum logic [1:0] {
        ph_addr,
        ph_reg,
        ph_data
    } phase_type;

    typedef struct packed {
        logic [7:0] idle;
        logic [7:0] rate;
    } tp_type;

    typedef struct packed {
        logic [3:0] out;
        logic [3:0] oe;
    } strap_pin_type;

endpackage

// ---- tp_cfg_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tp_cfg_map.svh"

module tp_cfg_regs (
    input  wire logic                      clk_i,
    input  wire logic                      reset_n_i,
    input  wire logic                      scl_i,
    input  wire logic                      sda_i,
    output logic                           sda_o,
    output logic                           sda_oe_o,
    input  wire logic [7:0]                idle_detect_i,
    input  wire logic [7:0]                rate_detect_i,
    input  wire logic [3:0]                strap_i,
    output tp_cfg_pkg::strap_pin_type      strap_pin_o,
    output tp_cfg_pkg::tp_type             test_point_o,
    output logic [1:0]                     global_swing_trim_o
);
    import tp_cfg_pkg::*;

    logic        scl_s, sda_s, scl_prev_q, sda_prev_q;
    logic        scl_n_s, sda_n_s;
    logic [7:0]  idle_s, rate_s;
    logic [3:0]  strap_s;
    logic [7:0]  idle_tp_q, rate_tp_q, strap_ctrl_q;
    logic [7:0]  ptr_q, shift_q, rd_byte;
    logic [3:0]  cnt_q;
    logic [1:0]  settle_q;
    logic [3:0]  addr_low_q;
    logic        rw_q;
    state_type   state_q;
    phase_type   phase_q;

    // pins into the clock domain; bus lines pass inverted so that the
    // cleared synchroniser matches the idle-high bus and no false edge follows reset
    tp_sync #(.WIDTH(2)) u_bus_sync (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .async_i   (~{scl_i, sda_i}),
        .sync_o    ({scl_n_s, sda_n_s})
    );
    assign scl_s = ~scl_n_s;
    assign sda_s = ~sda_n_s;
    tp_sync #(.WIDTH(20)) u_pin_sync (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .async_i   ({idle_detect_i, rate_detect_i, strap_i}),
        .sync_o    ({idle_s, rate_s, strap_s})
    );

    // bus event decode
    wire scl_rise   = scl_s & ~scl_prev_q;
    wire scl_fall   = ~scl_s & scl_prev_q;
    wire bus_start  = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
    wire bus_stop   = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
    wire byte_full  = (cnt_q == 4'h8);
    wire addr_match = (shift_q[7:1] == {`MGMT_ADDR_BASE, addr_low_q});
    wire wr_strobe  = (state_q == st_rx) && scl_fall && byte_full && (phase_q == ph_data);
    wire wr_idle    = wr_strobe && (ptr_q == `IDLE_TP_OFFSET);
    wire wr_rate    = wr_strobe && (ptr_q == `RATE_TP_OFFSET);
    wire wr_strap   = wr_strobe && (ptr_q == `STRAP_CTRL_OFFSET);

    // read mux; unmapped offsets read zero
    assign rd_byte = (ptr_q == `IDLE_TP_OFFSET)    ? idle_tp_q    :
                     (ptr_q == `RATE_TP_OFFSET)    ? rate_tp_q    :
                     (ptr_q == `STRAP_CTRL_OFFSET) ? strap_ctrl_q : 8'h00;

    // per-channel test point enables
    wire [7:0] idle_en = ({8{idle_tp_q[`IDLE_HI_BIT]}} & `GROUP_HI_MASK) // RQ1
                       | ({8{idle_tp_q[`IDLE_LO_BIT]}} & `GROUP_LO_MASK); // RQ2
    wire [7:0] rate_en = ({8{rate_tp_q[`RATE_HI_BIT]}} & `GROUP_HI_MASK) // RQ4
                       | ({8{rate_tp_q[`RATE_LO_BIT]}} & `GROUP_LO_MASK); // RQ5
    wire [7:0] idle_tp = idle_s & idle_en;
    wire [7:0] rate_tp = rate_s & rate_en;
    wire [3:0] strap_drv;
    for (genvar i = 0; i < 4; i++) begin : g_strap
        assign strap_drv[i] = |{idle_tp[2*i+1 -: 2], rate_tp[2*i+1 -: 2]};
    end

    // edge history of the bus lines
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_prev_q <= scl_s;
            sda_prev_q <= sda_s;
        end
    end

    // strap capture after reset release, once synchronised
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            settle_q   <= 2'h0;
            addr_low_q <= 4'h0;
        end else if (settle_q != `STRAP_SETTLE) begin
            settle_q   <= settle_q + 2'h1;
            addr_low_q <= strap_s;
        end
    end

    // register storage, reserved bits kept as written
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            idle_tp_q    <= `IDLE_TP_RESET;
            rate_tp_q    <= `RATE_TP_RESET;
            strap_ctrl_q <= `STRAP_CTRL_RESET;
        end else begin
            if (wr_idle)  idle_tp_q    <= shift_q; // RQ7
            if (wr_rate)  rate_tp_q    <= shift_q;
            if (wr_strap) strap_ctrl_q <= shift_q;
        end
    end

    // registered outputs towards pins and analog
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            test_point_o        <= '0;
            strap_pin_o         <= '0;
            global_swing_trim_o <= 2'h2;
            sda_o               <= 1'b0;
        end else begin
            test_point_o.idle   <= idle_tp; // RQ1 RQ2
            test_point_o.rate   <= rate_tp; // RQ4 RQ5
            strap_pin_o.out     <= strap_drv;
            strap_pin_o.oe      <= {4{strap_ctrl_q[`STRAP_OUT_BIT]}}; // RQ6
            global_swing_trim_o <= idle_tp_q[`TRIM_MSB:`TRIM_LSB]; // RQ3
            sda_o               <= 1'b0;
        end
    end

    // serial management slave
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q  <= st_idle;
            phase_q  <= ph_addr;
            cnt_q    <= 4'h0;
            shift_q  <= 8'h00;
            ptr_q    <= 8'h00;
            rw_q     <= 1'b0;
            sda_oe_o <= 1'b0;
        end else if (bus_stop) begin
            state_q  <= st_idle;
            sda_oe_o <= 1'b0;
        end else if (bus_start) begin
            state_q  <= st_rx;
            phase_q  <= ph_addr;
            cnt_q    <= 4'h0;
            sda_oe_o <= 1'b0;
        end else begin
            unique case (state_q)
                st_idle: begin
                    sda_oe_o <= 1'b0;
                end
                st_rx: begin
                    if (scl_rise && !byte_full) begin
                        shift_q <= {shift_q[6:0], sda_s};
                        cnt_q   <= cnt_q + 4'h1;
                    end else if (scl_fall && byte_full) begin
                        cnt_q    <= 4'h0;
                        state_q  <= st_ack;
                        sda_oe_o <= 1'b1;
                        unique case (phase_q)
                            ph_addr: begin
                                rw_q <= shift_q[0];
                                if (!addr_match) begin
                                    state_q  <= st_idle;
                                    sda_oe_o <= 1'b0;
                                end
                            end
                            ph_reg:  ptr_q <= shift_q;
                            ph_data: ptr_q <= ptr_q + 8'h01;
                            default: state_q <= st_idle;
                        endcase
                    end
                end
                st_ack: begin
                    if (scl_fall) begin
                        if (phase_q == ph_addr && rw_q) begin
                            state_q  <= st_tx;
                            shift_q  <= {rd_byte[6:0], 1'b0};
                            sda_oe_o <= ~rd_byte[7];
                        end else begin
                            state_q  <= st_rx;
                            sda_oe_o <= 1'b0;
                            phase_q  <= (phase_q == ph_addr) ? ph_reg : ph_data;
                        end
                    end
                end
                st_tx: begin
                    if (scl_rise) begin
                        cnt_q <= cnt_q + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt_q == 4'h8) begin
                            state_q  <= st_tx_ack;
                            sda_oe_o <= 1'b0;
                            cnt_q    <= 4'h0;
                        end else begin
                            sda_oe_o <= ~shift_q[7];
                            shift_q  <= {shift_q[6:0], 1'b0};
                        end
                    end
                end
                st_tx_ack: begin
                    if (scl_rise) begin
                        state_q <= sda_s ? st_idle : st_tx_next;
                        ptr_q   <= ptr_q + 8'h01;
                    end
                end
                st_tx_next: begin
                    if (scl_fall) begin
                        state_q  <= st_tx;
                        shift_q  <= {rd_byte[6:0], 1'b0};
                        sda_oe_o <= ~rd_byte[7];
                    end
                end
            endcase
        end
    end

    sequence s_hi_group_on;
        idle_tp_q[`IDLE_HI_BIT] && $stable(idle_tp_q) && $stable(idle_s);
    endsequence

    a_idle_hi_group: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RQ1
        s_hi_group_on |=> test_point_o.idle[7:6] == $past(idle_s[7:6])
                          && test_point_o.idle[3:2] == $past(idle_s[3:2]))
        else $error("idle test points of upper group do not follow channels");

    a_idle_lo_off: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RQ2
        !$past(idle_tp_q[`IDLE_LO_BIT]) |-> (test_point_o.idle & `GROUP_LO_MASK) == 8'h00)
        else $error("idle test points of lower group active while disabled");

    a_swing_trim: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RQ3
        wr_idle ##1 1'b1 |=> global_swing_trim_o == $past(idle_tp_q[1:0]))
        else $error("swing trim does not follow written field");

    a_rate_hi_off: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RQ4
        !$past(rate_tp_q[`RATE_HI_BIT]) |-> (test_point_o.rate & `GROUP_HI_MASK) == 8'h00)
        else $error("rate test points of upper group active while disabled");

    a_rate_lo_group: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RQ5
        rate_tp_q[`RATE_LO_BIT] && $stable(rate_s)
        |=> (test_point_o.rate & `GROUP_LO_MASK) == ($past(rate_s) & `GROUP_LO_MASK))
        else $error("rate test points of lower group do not follow channels");

    a_strap_output: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RQ6
        wr_strap ##1 1'b1 |=> strap_pin_o.oe == {4{$past(strap_ctrl_q[0])}})
        else $error("strap pin enables do not follow control bit");

endmodule

`default_nettype wire

// ---- tp_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

module tp_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic             reset_n_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_q;

    // two flops; the first is read only by the second
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta_q <= '0;
            sync_o <= '0;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end

endmodule

`default_nettype wire
